// >>> core/mofu_cnt_if.sv
// interface between the unit and its outstanding-access counter
`timescale 1ns/1ps
interface mofu_cnt_if;
    logic inc;
    logic dec;
    logic zero;
    modport owner (output inc, output dec, input zero);
    modport counter (input inc, input dec, output zero);
endinterface

// >>> core/mofu_fence_unit.sv
// memory ordering fence unit: drains, fences, locks and string ordering
`timescale 1ns/1ps
`include "mofu_regs.svh"
module mofu_fence_unit
    import mofu_pkg::*;
#(
    parameter int CNT_W = `MOFU_CNT_W
) (
    input wire logic mclk_i, // core clock
    input wire logic srst_i, // sync reset, active high
    input wire logic ce_i, // clock enable
    input wire logic op_valid_i, // ordering op offered
    input wire mofu_op_t op_i, // ordering op kind
    input wire logic [`MOFU_MT_W-1:0] op_mtype_i, // memory type of op
    input wire logic op_split_i, // locked access crosses a line
    output logic op_ready_o, // ordering op accepted
    input wire logic rob_empty_i, // no older instruction in flight
    input wire logic sb_empty_i, // store buffer empty
    input wire logic st_issue_i, // store leaves for memory
    input wire logic st_ack_i, // store globally visible
    input wire logic ld_issue_i, // load issued
    input wire logic ld_done_i, // load data returned
    input wire logic port_done_i, // port access completed
    input wire logic lock_done_i, // locked rmw completed
    input wire logic str_done_i, // string op completed
    input wire logic str_intr_i, // string op interrupted
    input wire logic fast_str_en_i, // fast string enable
    input wire logic [`MOFU_MT_W-1:0] acc_mtype_i, // type of next access
    output logic port_go_o, // port access may start
    output logic lock_go_o, // locked rmw may start
    output logic serial_go_o, // serializing op may start
    output logic bus_lock_o, // assert bus lock
    output logic line_lock_o, // lock cache line
    output logic hold_st_o, // younger stores stall
    output logic hold_ld_o, // younger loads stall
    output logic hold_exec_o, // younger instructions stall
    output logic str_ooo_ok_o, // string stores may reorder
    output logic spec_ok_o, // speculative access allowed
    output logic combine_ok_o, // write combining allowed
    output logic in_order_o, // strict in-order required
    output logic str_resume_o // string must resume at instruction
);
    // ==========================================================
    // outstanding counters
    mofu_cnt_if st_cnt ();
    mofu_cnt_if ld_cnt ();
    mofu_state_e state_q;
    logic [`MOFU_BAR_W-1:0] bar_q;
    logic uc_lock_q;
    logic resume_q;
    logic st_drained;
    logic all_drained;
    logic take;

    initial begin
        if (CNT_W < 2) $error("mofu_fence_unit: CNT_W below 2");
    end

    assign st_cnt.inc = st_issue_i;
    assign st_cnt.dec = st_ack_i;
    assign ld_cnt.inc = ld_issue_i;
    assign ld_cnt.dec = ld_done_i;

    mofu_outstanding #(.WIDTH(CNT_W)) u_st_cnt (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .cnt(st_cnt)
    );
    mofu_outstanding #(.WIDTH(CNT_W)) u_ld_cnt (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .cnt(ld_cnt)
    );

    // ==========================================================
    // drain conditions
    // buffer empty and every store acknowledged
    assign st_drained = sb_empty_i && st_cnt.zero;
    // older instructions done, writes drained and loads returned
    assign all_drained = st_drained && rob_empty_i && ld_cnt.zero;

    // ==========================================================
    // state machine
    assign take = op_valid_i && op_ready_o;
    // only idle accepts a new op; a fence finishes while draining
    assign op_ready_o = (state_q == MOFU_IDLE);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q <= MOFU_IDLE;
        end else if (ce_i) begin
            case (state_q)
                MOFU_IDLE: begin
                    if (take) begin
                        case (op_i)
                            MOFU_OP_PORT: state_q <= MOFU_PORT;
                            MOFU_OP_LOCK: state_q <= MOFU_LOCK;
                            MOFU_OP_SERIAL: state_q <= MOFU_SERIAL;
                            MOFU_OP_STRING: state_q <= MOFU_STRING;
                            MOFU_OP_NONE: state_q <= MOFU_IDLE;
                            default: state_q <= MOFU_DRAIN;
                        endcase
                    end
                end
                MOFU_DRAIN: begin
                    // fence releases when its ordered class is drained
                    if ((!bar_q[`MOFU_BAR_ST] || st_drained) &&
                        (!bar_q[`MOFU_BAR_LD] || ld_cnt.zero)) begin
                        state_q <= MOFU_IDLE;
                    end
                end
                MOFU_PORT: begin
                    if (port_done_i) begin
                        state_q <= MOFU_IDLE;
                    end
                end
                MOFU_LOCK: begin
                    if (lock_done_i) begin
                        state_q <= MOFU_IDLE;
                    end
                end
                MOFU_SERIAL: begin
                    if (all_drained) begin
                        state_q <= MOFU_IDLE;
                    end
                end
                MOFU_STRING: begin
                    // interrupt ends the wait so handler stores pass
                    if (str_intr_i || (str_done_i)) begin
                        state_q <= MOFU_IDLE;
                    end
                end
                default: state_q <= MOFU_IDLE;
            endcase
        end
    end

    // barrier classes held by a fence
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bar_q <= '0;
        end else if (ce_i && take) begin
            case (op_i)
                MOFU_OP_STORE_FENCE: bar_q <= 3'b001;
                MOFU_OP_LOAD_FENCE: bar_q <= 3'b010;
                MOFU_OP_FULL_FENCE: bar_q <= 3'b011;
                default: bar_q <= 3'b000;
            endcase
        end
    end

    // lock flavour: bus lock for any type other than write-back or for split, line lock otherwise
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            uc_lock_q <= 1'b0;
        end else if (ce_i && take && op_i == MOFU_OP_LOCK) begin
            uc_lock_q <= (op_mtype_i != `MOFU_MT_WB) || op_split_i;
        end
    end

    // interrupted string must restart at its own instruction
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            resume_q <= 1'b0;
        end else if (ce_i) begin
            if (state_q == MOFU_STRING && str_intr_i) begin
                resume_q <= 1'b1;
            end else if (take && op_i == MOFU_OP_STRING) begin
                resume_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // go and hold outputs
    // port and lock start only once everything older is drained
    assign port_go_o = (state_q == MOFU_PORT) && all_drained;
    assign lock_go_o = (state_q == MOFU_LOCK) && all_drained;
    assign serial_go_o = (state_q == MOFU_SERIAL) && all_drained;
    assign bus_lock_o = lock_go_o && uc_lock_q;
    assign line_lock_o = lock_go_o && !uc_lock_q;

    // younger data accesses wait; fetches and walks are not held
    always_comb begin
        hold_st_o = 1'b0;
        hold_ld_o = 1'b0;
        hold_exec_o = 1'b0;
        case (state_q)
            MOFU_PORT, MOFU_LOCK, MOFU_SERIAL: begin
                hold_st_o = 1'b1;
                hold_ld_o = 1'b1;
                hold_exec_o = 1'b1;
            end
            MOFU_DRAIN: begin
                hold_st_o = bar_q[`MOFU_BAR_ST];
                hold_ld_o = bar_q[`MOFU_BAR_LD];
            end
            MOFU_STRING: begin
                // string stores wait for prior ones; later stores wait
                hold_st_o = !st_drained;
            end
            default: begin
                hold_st_o = 1'b0;
            end
        endcase
        // strictly ordered type: nothing passes an outstanding access
        if (acc_mtype_i == `MOFU_MT_UC && !all_drained) begin
            hold_st_o = 1'b1;
            hold_ld_o = 1'b1;
        end
    end

    // ==========================================================
    // memory type policy
    assign in_order_o = (acc_mtype_i == `MOFU_MT_UC);
    assign spec_ok_o = (acc_mtype_i == `MOFU_MT_WB);
    assign combine_ok_o = (acc_mtype_i == `MOFU_MT_WB) ||
                          (acc_mtype_i == `MOFU_MT_WC);
    assign str_ooo_ok_o = (state_q == MOFU_STRING) && fast_str_en_i &&
                          (acc_mtype_i != `MOFU_MT_UC);
    assign str_resume_o = resume_q;

    // ==========================================================
    // checks
    a_port_after_drain: assert property (@(posedge mclk_i)
        disable iff (srst_i) port_go_o |-> sb_empty_i && rob_empty_i)
        else $error("port access started before drain");
    a_port_holds_exec: assert property (@(posedge mclk_i)
        disable iff (srst_i) state_q == MOFU_PORT |-> hold_exec_o)
        else $error("execution not held during port access");
    a_lock_kind: assert property (@(posedge mclk_i)
        disable iff (srst_i) !(bus_lock_o && line_lock_o))
        else $error("both bus and line lock");
    a_lock_drain: assert property (@(posedge mclk_i)
        disable iff (srst_i) lock_go_o |-> st_drained && rob_empty_i)
        else $error("lock started before drain");
    sequence s_sf_take;
        take && op_i == MOFU_OP_STORE_FENCE && ce_i;
    endsequence
    a_store_fence_hold: assert property (@(posedge mclk_i)
        disable iff (srst_i) s_sf_take ##1 !st_drained |-> hold_st_o)
        else $error("store fence let stores pass");
    a_load_fence_free: assert property (@(posedge mclk_i)
        disable iff (srst_i) state_q == MOFU_DRAIN && bar_q == 3'b010
        && acc_mtype_i != `MOFU_MT_UC |-> !hold_st_o)
        else $error("load fence held stores");
    a_full_fence_hold: assert property (@(posedge mclk_i)
        disable iff (srst_i) state_q == MOFU_DRAIN && bar_q == 3'b011
        |-> hold_st_o && hold_ld_o)
        else $error("full fence let accesses pass");
    a_serial_wait: assert property (@(posedge mclk_i)
        disable iff (srst_i) serial_go_o |-> st_drained)
        else $error("serializing op before drain");
    a_uc_no_spec: assert property (@(posedge mclk_i)
        disable iff (srst_i) in_order_o |-> !spec_ok_o && !str_ooo_ok_o)
        else $error("speculation on uncached");
    a_str_fast: assert property (@(posedge mclk_i)
        disable iff (srst_i) !fast_str_en_i |-> !str_ooo_ok_o)
        else $error("string reorder without fast strings");
    a_str_resume: assert property (@(posedge mclk_i)
        disable iff (srst_i) state_q == MOFU_STRING && str_intr_i && ce_i
        |=> str_resume_o && op_ready_o)
        else $error("interrupted string not released");
endmodule

// >>> core/mofu_outstanding.sv
// counter of issued but not yet acknowledged accesses
`timescale 1ns/1ps
`include "mofu_regs.svh"
module mofu_outstanding #(
    parameter int WIDTH = `MOFU_CNT_W
) (
    input wire logic mclk_i, // core clock
    input wire logic srst_i, // sync reset
    input wire logic ce_i, // clock enable
    mofu_cnt_if.counter cnt // count control
);
    logic [WIDTH-1:0] cnt_q;
    initial begin
        if (WIDTH < 1) $error("mofu_outstanding: WIDTH below 1");
    end
    // count up on issue, down on acknowledge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            if (cnt.inc && !cnt.dec) begin
                cnt_q <= cnt_q + WIDTH'(1);
            end else if (cnt.dec && !cnt.inc) begin
                cnt_q <= cnt_q - WIDTH'(1);
            end
        end
    end
    assign cnt.zero = (cnt_q == '0);
endmodule

// >>> core/mofu_pkg.sv
// types for the memory ordering fence unit
package mofu_pkg;
    typedef enum logic [5:0] {
        MOFU_IDLE = 6'b00_0001,
        MOFU_DRAIN = 6'b00_0010,
        MOFU_PORT = 6'b00_0100,
        MOFU_LOCK = 6'b00_1000,
        MOFU_SERIAL = 6'b01_0000,
        MOFU_STRING = 6'b10_0000
    } mofu_state_e;
    typedef enum logic [2:0] {
        MOFU_OP_NONE = 3'h0,
        MOFU_OP_PORT = 3'h1,
        MOFU_OP_LOCK = 3'h2,
        MOFU_OP_SERIAL = 3'h3,
        MOFU_OP_STORE_FENCE = 3'h4,
        MOFU_OP_LOAD_FENCE = 3'h5,
        MOFU_OP_FULL_FENCE = 3'h6,
        MOFU_OP_STRING = 3'h7
    } mofu_op_t;
endpackage

// >>> core/mofu_regs.svh
// constants for the memory ordering fence unit
`ifndef MOFU_REGS_SVH
`define MOFU_REGS_SVH
`define MOFU_SB_DEPTH 8
`define MOFU_CNT_W 4
`define MOFU_MT_W 2
`define MOFU_MT_UC 2'h0
`define MOFU_MT_WB 2'h1
`define MOFU_MT_WT 2'h2
`define MOFU_MT_WC 2'h3
`define MOFU_BAR_W 3
`define MOFU_BAR_ST 0
`define MOFU_BAR_LD 1
`define MOFU_BAR_DR 2
`endif

// >>> verification/mofu_fence_unit_tb.sv
// self-checking bench for the memory ordering fence unit
`timescale 1ns/1ps
`include "mofu_regs.svh"
module mofu_fence_unit_tb
    import mofu_pkg::*;
;
    logic mclk_i = 1'b0;
    logic srst_i, ce_i, op_valid_i, op_split_i, rob_empty_i, sb_empty_i;
    logic st_issue_i, ld_issue_i, port_done_i, lock_done_i, str_done_i;
    logic str_intr_i, fast_str_en_i, st_ack_i, ld_done_i, st_busy, ld_busy;
    logic op_ready_o, port_go_o, lock_go_o, serial_go_o, bus_lock_o;
    logic line_lock_o, hold_st_o, hold_ld_o, hold_exec_o, str_ooo_ok_o;
    logic spec_ok_o, combine_ok_o, in_order_o, str_resume_o;
    logic [`MOFU_MT_W-1:0] op_mtype_i, acc_mtype_i;
    logic [3:0] lat;
    mofu_op_t op_i;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // ==========
    // clock, units
    always #2.5 mclk_i = ~mclk_i;
    mofu_fence_unit mofu_fence_unit_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .ce_i(ce_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .op_mtype_i(op_mtype_i), .op_split_i(op_split_i),
        .op_ready_o(op_ready_o), .rob_empty_i(rob_empty_i),
        .sb_empty_i(sb_empty_i), .st_issue_i(st_issue_i),
        .st_ack_i(st_ack_i), .ld_issue_i(ld_issue_i), .ld_done_i(ld_done_i),
        .port_done_i(port_done_i), .lock_done_i(lock_done_i),
        .str_done_i(str_done_i), .str_intr_i(str_intr_i),
        .fast_str_en_i(fast_str_en_i), .acc_mtype_i(acc_mtype_i),
        .port_go_o(port_go_o), .lock_go_o(lock_go_o),
        .serial_go_o(serial_go_o), .bus_lock_o(bus_lock_o),
        .line_lock_o(line_lock_o), .hold_st_o(hold_st_o),
        .hold_ld_o(hold_ld_o), .hold_exec_o(hold_exec_o),
        .str_ooo_ok_o(str_ooo_ok_o), .spec_ok_o(spec_ok_o),
        .combine_ok_o(combine_ok_o), .in_order_o(in_order_o),
        .str_resume_o(str_resume_o));
    mofu_mem_model mofu_mem_model_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .issue_i(st_issue_i), .lat_i(lat), .done_o(st_ack_i),
        .busy_o(st_busy));
    mofu_mem_model mofu_mem_model_ld_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .issue_i(ld_issue_i), .lat_i(lat), .done_o(ld_done_i),
        .busy_o(ld_busy));
    // ==========
    // helpers
    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic take(input mofu_op_t op);
        op_valid_i = 1'b1;
        op_i = op;
        tick();
        op_valid_i = 1'b0;
        op_i = MOFU_OP_NONE;
    endtask
    task automatic issue(input logic st, input logic ld);
        st_issue_i = st;
        ld_issue_i = ld;
        tick();
        st_issue_i = 1'b0;
        ld_issue_i = 1'b0;
    endtask
    task automatic wait_mem;
        for (int i = 0; i < 40 && (st_busy || ld_busy); i++) tick();
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 40 && op_ready_o !== 1'b1; i++) tick();
        chk(op_ready_o, 1'b1);
    endtask
    // ==========
    // scenarios
    task automatic t_mtype;
        for (int m = 0; m < 4; m++) begin
            acc_mtype_i = m[1:0];
            tick();
            chk(in_order_o, acc_mtype_i == `MOFU_MT_UC);
            chk(spec_ok_o, acc_mtype_i == `MOFU_MT_WB);
            chk(combine_ok_o, m == 1 || m == 3);
        end
        acc_mtype_i = `MOFU_MT_WB;
    endtask
    task automatic t_port;
        sb_empty_i = 1'b0;
        issue(1'b1, 1'b0);
        take(MOFU_OP_PORT);
        chk({port_go_o, op_ready_o}, 4'h0);
        chk({hold_exec_o, hold_ld_o, hold_st_o}, 4'h7);
        wait_mem();
        chk(port_go_o, 1'b0);
        sb_empty_i = 1'b1;
        #1;
        chk(port_go_o, 1'b1);
        tick();
        port_done_i = 1'b1;
        tick();
        port_done_i = 1'b0;
        chk({op_ready_o, hold_exec_o}, 4'h2);
    endtask
    task automatic t_lock;
        logic [1:0] mt [3] = '{`MOFU_MT_WB, `MOFU_MT_UC, `MOFU_MT_WB};
        for (int k = 0; k < 3; k++) begin
            op_mtype_i = mt[k];
            op_split_i = (k == 2);
            rob_empty_i = 1'b0;
            take(MOFU_OP_LOCK);
            chk(lock_go_o, 1'b0);
            rob_empty_i = 1'b1;
            #1;
            chk(lock_go_o, 1'b1);
            chk(bus_lock_o, k != 0);
            chk(line_lock_o, k == 0);
            tick();
            lock_done_i = 1'b1;
            tick();
            lock_done_i = 1'b0;
            chk(op_ready_o, 1'b1);
        end
    endtask
    task automatic t_serial;
        rob_empty_i = 1'b0;
        take(MOFU_OP_SERIAL);
        chk(serial_go_o, 1'b0);
        rob_empty_i = 1'b1;
        #1;
        chk(serial_go_o, 1'b1);
        tick();
        chk(op_ready_o, 1'b1);
    endtask
    task automatic t_fence;
        mofu_op_t ops [3] = '{MOFU_OP_STORE_FENCE, MOFU_OP_LOAD_FENCE, MOFU_OP_FULL_FENCE};
        for (int k = 0; k < 3; k++) begin
            issue(1'b1, 1'b0);
            issue(1'b0, 1'b1);
            take(ops[k]);
            chk(hold_st_o, k != 1);
            chk(hold_ld_o, k != 0);
            wait_ready();
            wait_mem();
        end
    endtask
    task automatic t_string;
        issue(1'b1, 1'b0);
        take(MOFU_OP_STRING);
        chk({hold_st_o, str_ooo_ok_o}, 4'h3);
        fast_str_en_i = 1'b0;
        #1;
        chk(str_ooo_ok_o, 1'b0);
        fast_str_en_i = 1'b1;
        acc_mtype_i = `MOFU_MT_UC;
        #1;
        chk(str_ooo_ok_o, 1'b0);
        acc_mtype_i = `MOFU_MT_WB;
        tick();
        str_intr_i = 1'b1;
        tick();
        str_intr_i = 1'b0;
        chk({op_ready_o, str_resume_o, hold_st_o}, 4'h6);
        wait_mem();
        take(MOFU_OP_STRING);
        chk(str_resume_o, 1'b0);
        str_done_i = 1'b1;
        tick();
        str_done_i = 1'b0;
        chk(op_ready_o, 1'b1);
    endtask
    // ==========
    // verdict and hang guard
    task automatic end_sim;
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        srst_i = 1'b1;
        ce_i = 1'b1;
        op_valid_i = 1'b0;
        op_i = MOFU_OP_NONE;
        {op_split_i, st_issue_i, ld_issue_i, str_intr_i} = 4'h0;
        {port_done_i, lock_done_i, str_done_i} = 3'h0;
        {rob_empty_i, sb_empty_i, fast_str_en_i} = 3'h7;
        op_mtype_i = `MOFU_MT_WB;
        acc_mtype_i = `MOFU_MT_WB;
        lat = 4'h5;
        repeat (12) tick();
        srst_i = 1'b0;
        chk({op_ready_o, port_go_o, str_resume_o}, 4'h4);
        t_mtype();
        t_port();
        t_lock();
        t_serial();
        t_fence();
        t_string();
        end_sim();
    end
endmodule

// >>> verification/mofu_mem_model.sv
// shared memory side: acknowledges each issued access after a delay
`timescale 1ns/1ps
module mofu_mem_model (
    input wire logic mclk_i, // core clock
    input wire logic srst_i, // sync reset
    input wire logic issue_i, // access leaves the core
    input wire logic [3:0] lat_i, // wait before acknowledge
    output logic done_o, // access globally visible
    output logic busy_o // accesses not yet counted back
);
    logic [3:0] pend_q;
    logic [3:0] wait_q;
    logic fire;
    // ==========
    // acknowledge one pending access once the wait has run out
    assign fire = (pend_q != 4'h0) && (wait_q >= lat_i);
    assign busy_o = (pend_q != 4'h0) || done_o;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pend_q <= 4'h0;
            wait_q <= 4'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= fire;
            pend_q <= pend_q + {3'h0, issue_i} - {3'h0, fire};
            wait_q <= (fire || pend_q == 4'h0) ? 4'h0 : wait_q + 4'h1;
        end
    end
endmodule
